//--- rtl/blt_pkg.sv
// Purpose: shared constants for the bidirectional latch/register transceiver
// Assumes: single 100 MHz system clock, asynchronous active-high reset
// Notes:   reset values cover storage, pin enables, control sync and capture clock history
package blt_pkg;
    localparam int unsigned BLT_DATA_W      = 36;       // word width per direction
    localparam logic [35:0] BLT_STORE_RST   = 36'h0;    // storage value after reset
    localparam logic        BLT_OE_N_RST    = 1'b1;     // pin enable (low = drive) after reset
    localparam logic [5:0]  BLT_CTL_RST     = 6'h02;    // control sync after reset: enables off
    localparam logic        BLT_CLK_D_RST   = 1'b0;     // capture clock history after reset
    localparam int unsigned BLT_SYNC_STAGES = 2;        // flip-flops before any pin is read
endpackage

//--- rtl/blt_transceiver.sv
// Purpose: 36-bit two-way bus transceiver, each direction transparent, held or clocked
// Assumes: all pins are asynchronous to sys_clk and pass two flip-flops first;
//          capture clocks are sampled as levels, their rising edge found on sys_clk
// Notes:   pins are split into in/out/oe_n; oe_n low means the pin is driven
`timescale 1ns/1ps
`default_nettype none

module blt_transceiver
#(
    parameter int unsigned DATA_W = blt_pkg::BLT_DATA_W  // word width
)(
    input  wire logic              sys_clk,                // system clock
    input  wire logic              rst,                    // async reset, active high
    input  wire logic [DATA_W-1:0] a_in,                   // a bus level seen at pins
    output var  logic [DATA_W-1:0] a_out,                  // a bus drive value
    output var  logic              a_oe_n,                 // low while a is driven
    input  wire logic [DATA_W-1:0] b_in,                   // b bus level seen at pins
    output var  logic [DATA_W-1:0] b_out,                  // b bus drive value
    output var  logic              b_oe_n,                 // low while b is driven
    input  wire logic              a_to_b_output_enable,   // high drives b
    input  wire logic              b_to_a_output_enable_n, // low drives a
    input  wire logic              a_to_b_latch_enable,    // high: a-to-b transparent
    input  wire logic              b_to_a_latch_enable,    // high: b-to-a transparent
    input  wire logic              a_to_b_capture_clock,   // a-to-b capture clock pin
    input  wire logic              b_to_a_capture_clock    // b-to-a capture clock pin
);
    import blt_pkg::*;

    // synchroniser stages: [0] first flop, [1] second flop
    logic [DATA_W-1:0] a_s0_r, a_s1_r;     // a data sync
    logic [DATA_W-1:0] b_s0_r, b_s1_r;     // b data sync
    logic [5:0]        ctl_s0_r, ctl_s1_r; // control pins sync
    logic              ab_clk_d_r;         // delayed a-to-b clock for edge find
    logic              ba_clk_d_r;         // delayed b-to-a clock for edge find
    logic [DATA_W-1:0] ab_store_r;         // a-to-b storage cells
    logic [DATA_W-1:0] ba_store_r;         // b-to-a storage cells
    logic [DATA_W-1:0] a_hold_r;           // last valid level on a
    logic [DATA_W-1:0] b_hold_r;           // last valid level on b
    logic [DATA_W-1:0] a_clean;            // a data with unknown bits replaced
    logic [DATA_W-1:0] b_clean;            // b data with unknown bits replaced

    // named views of the synchronised control pins
    logic ab_oe, ba_oe_n, ab_le, ba_le, ab_clk, ba_clk;
    assign ab_oe   = ctl_s1_r[0];
    assign ba_oe_n = ctl_s1_r[1];
    assign ab_le   = ctl_s1_r[2];
    assign ba_le   = ctl_s1_r[3];
    assign ab_clk  = ctl_s1_r[4];
    assign ba_clk  = ctl_s1_r[5];

    // timing through the block, counted in sys_clk edges:
    //   edge n    a pin level lands in the first synchroniser flop
    //   edge n+1  it reaches the second flop and is first read by logic
    //   edge n+2  the storage cell loads it (transparent or on a clock rise)
    //   edge n+3  the output register shows it on a_out or b_out
    // the output enables skip the storage stage, so a pin enable reaches
    // a_oe_n or b_oe_n one edge earlier than data reaches a_out or b_out;
    // a newly enabled driver therefore shows the word already stored

    // replace floating bits by the held level, bit by bit
    // only floating or unknown bits are replaced; driven bits pass unchanged
    function automatic logic [DATA_W-1:0] keep_valid(
        input logic [DATA_W-1:0] now_v,
        input logic [DATA_W-1:0] last_v
    );
        logic [DATA_W-1:0] res;
        res = now_v;
        for (int i = 0; i < DATA_W; i++)
        begin
            if (now_v[i] !== 1'b0 && now_v[i] !== 1'b1)
            begin
                res[i] = last_v[i];
            end
        end
        return res;
    endfunction

    // rising edge of a synchronised capture clock
    // both inputs are synchronised levels of the same pin
    function automatic logic rose(input logic now_v, input logic prev_v);
        return now_v & ~prev_v;
    endfunction

    // two-flop synchronisers for every pin input
    // reset leaves both output enables reading inactive, so no pin is driven
    // until the pins have been sampled twice after release
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            a_s0_r   <= BLT_STORE_RST;
            a_s1_r   <= BLT_STORE_RST;
            b_s0_r   <= BLT_STORE_RST;
            b_s1_r   <= BLT_STORE_RST;
            ctl_s0_r <= BLT_CTL_RST;
            ctl_s1_r <= BLT_CTL_RST;
        end
        else
        begin
            a_s0_r   <= a_in;
            a_s1_r   <= a_s0_r;
            b_s0_r   <= b_in;
            b_s1_r   <= b_s0_r;
            ctl_s0_r <= {b_to_a_capture_clock, a_to_b_capture_clock,
                         b_to_a_latch_enable, a_to_b_latch_enable,
                         b_to_a_output_enable_n, a_to_b_output_enable};
            ctl_s1_r <= ctl_s0_r;
        end
    end

    // bus hold: remember last valid data level
    // a floating input bit keeps the level it last had, so a bus left
    // undriven never pushes unknown values into the storage cells
    assign a_clean = keep_valid(a_s1_r, a_hold_r);
    assign b_clean = keep_valid(b_s1_r, b_hold_r);

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            a_hold_r <= BLT_STORE_RST;
            b_hold_r <= BLT_STORE_RST;
        end
        else
        begin
            a_hold_r <= a_clean;
            b_hold_r <= b_clean;
        end
    end

    // capture clock history for edge detection
    // a capture clock must stay high for more than one sys_clk period and low for more than one;
    // a shorter pulse may slip between samples and never be seen as a rise.
    // the history resets low, like the synchronised clock, so leaving reset
    // with the clock pin low makes no false capture
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ab_clk_d_r <= BLT_CLK_D_RST;
            ba_clk_d_r <= BLT_CLK_D_RST;
        end
        else
        begin
            ab_clk_d_r <= ab_clk;
            ba_clk_d_r <= ba_clk;
        end
    end

    // a-to-b storage: transparent, clocked or held; runs regardless of enable
    // latch enable wins over the clock: a rise while transparent is ignored,
    // and a fall of the enable while the clock is high loads nothing
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ab_store_r <= BLT_STORE_RST;
        end
        else if (ab_le)
        begin
            ab_store_r <= a_clean;
        end
        else if (rose(ab_clk, ab_clk_d_r))
        begin
            ab_store_r <= a_clean;
        end
        // otherwise keep the word, whether clock sits high or low
    end

    // b-to-a storage: same three modes on its own controls
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ba_store_r <= BLT_STORE_RST;
        end
        else if (ba_le)
        begin
            ba_store_r <= b_clean;
        end
        else if (rose(ba_clk, ba_clk_d_r))
        begin
            ba_store_r <= b_clean;
        end
        // otherwise keep the word, whether clock sits high or low
    end

    // output registers: stored word follows storage, drivers follow enables
    // a disabled direction still updates its drive value; only oe_n gates it
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            b_out  <= BLT_STORE_RST;
            a_out  <= BLT_STORE_RST;
            b_oe_n <= BLT_OE_N_RST;
            a_oe_n <= BLT_OE_N_RST;
        end
        else
        begin
            b_out  <= ab_store_r;
            a_out  <= ba_store_r;
            b_oe_n <= ~ab_oe;
            a_oe_n <= ba_oe_n;
        end
    end

endmodule

`default_nettype wire

//--- tb/blt_properties.sv
// Purpose: port checks for blt_transceiver
// Assumes: a data pin sampled at one edge shows on outputs four edges on,
//          an output enable pin three edges on
// Notes: history from before a reset is not trusted
`timescale 1ns/1ps
`default_nettype none
module blt_properties #(
    parameter int unsigned DATA_W = 36                    // word width
)(
    input wire logic              sys_clk,                // system clock
    input wire logic              rst,                    // async reset, active high
    input wire logic [DATA_W-1:0] a_in,                   // a bus level
    input wire logic [DATA_W-1:0] a_out,                  // a drive value
    input wire logic              a_oe_n,                 // low while a driven
    input wire logic [DATA_W-1:0] b_in,                   // b bus level
    input wire logic [DATA_W-1:0] b_out,                  // b drive value
    input wire logic              b_oe_n,                 // low while b driven
    input wire logic              a_to_b_output_enable,   // high drives b
    input wire logic              b_to_a_output_enable_n, // low drives a
    input wire logic              a_to_b_latch_enable,    // a-to-b transparent
    input wire logic              b_to_a_latch_enable,    // b-to-a transparent
    input wire logic              a_to_b_capture_clock,   // a-to-b capture clock
    input wire logic              b_to_a_capture_clock    // b-to-a capture clock
);
    logic [2:0] up_r; // edges since reset, saturating
    // count clean edges after reset
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            up_r <= 3'h0;
        end
        else if (up_r != 3'h7)
        begin
            up_r <= up_r + 3'h1;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // capture clock pins rose
    sequence ab_rise; !$past(a_to_b_capture_clock, 5) && $past(a_to_b_capture_clock, 4);
    endsequence
    sequence ba_rise; !$past(b_to_a_capture_clock, 5) && $past(b_to_a_capture_clock, 4);
    endsequence
    ab_pass_a: assert property (up_r == 3'h7 && $past(a_to_b_latch_enable, 4)
        |-> b_out == $past(a_in, 4)) else $error("b not following a");
    ab_hold_a: assert property (up_r == 3'h7 && !$past(a_to_b_latch_enable, 4) &&
        $past(a_to_b_capture_clock, 4) == $past(a_to_b_capture_clock, 5) |-> $stable(b_out))
        else $error("b moved while held");
    ab_load_a: assert property (up_r == 3'h7 && !$past(a_to_b_latch_enable, 4) ##0 ab_rise
        |-> b_out == $past(a_in, 4)) else $error("b missed capture");
    ab_drive_a: assert property (up_r == 3'h7
        |-> b_oe_n == !$past(a_to_b_output_enable, 3)) else $error("b enable wrong");
    ba_pass_a: assert property (up_r == 3'h7 && $past(b_to_a_latch_enable, 4)
        |-> a_out == $past(b_in, 4)) else $error("a not following b");
    ba_hold_a: assert property (up_r == 3'h7 && !$past(b_to_a_latch_enable, 4) &&
        $past(b_to_a_capture_clock, 4) == $past(b_to_a_capture_clock, 5) |-> $stable(a_out))
        else $error("a moved while held");
    ba_load_a: assert property (up_r == 3'h7 && !$past(b_to_a_latch_enable, 4) ##0 ba_rise
        |-> a_out == $past(b_in, 4)) else $error("a missed capture");
    ba_drive_a: assert property (up_r == 3'h7
        |-> a_oe_n == $past(b_to_a_output_enable_n, 3)) else $error("a enable wrong");
endmodule
bind blt_transceiver blt_properties #(
    .DATA_W(DATA_W)
) chk (
    .sys_clk                (sys_clk),
    .rst                    (rst),
    .a_in                   (a_in),
    .a_out                  (a_out),
    .a_oe_n                 (a_oe_n),
    .b_in                   (b_in),
    .b_out                  (b_out),
    .b_oe_n                 (b_oe_n),
    .a_to_b_output_enable   (a_to_b_output_enable),
    .b_to_a_output_enable_n (b_to_a_output_enable_n),
    .a_to_b_latch_enable    (a_to_b_latch_enable),
    .b_to_a_latch_enable    (b_to_a_latch_enable),
    .a_to_b_capture_clock   (a_to_b_capture_clock),
    .b_to_a_capture_clock   (b_to_a_capture_clock)
);
`default_nettype wire

//--- tb/blt_bus_party.sv
// Purpose: far-side logic sharing one bus wire with the transceiver
// Assumes: it drives whenever the transceiver lets go
// Notes: lvl is what every input on the bus sees
`timescale 1ns/1ps
`default_nettype none
module blt_bus_party (
    input  wire logic [35:0] own_val,  // far logic drive value
    input  wire logic        dev_oe_n, // low while transceiver drives
    input  wire logic [35:0] dev_val,  // transceiver drive value
    output logic      [35:0] lvl       // resolved wire level
);
    // one driver at a time, never contention
    assign lvl = dev_oe_n ? own_val : dev_val;
endmodule
`default_nettype wire

//--- tb/blt_transceiver_test.sv
// Purpose: directed test of both transceiver directions
// Assumes: inputs change on the falling edge
// Notes: four edges from pin to output
`timescale 1ns/1ps
`default_nettype none
module blt_transceiver_test;
    logic        sys_clk, rst, a_oe_n, b_oe_n, a_to_b_output_enable, b_to_a_output_enable_n;
    logic        a_to_b_latch_enable, b_to_a_latch_enable;
    logic        a_to_b_capture_clock, b_to_a_capture_clock;
    logic [35:0] a_drv, b_drv, a_in, b_in, a_out, b_out;
    int          mismatches, total_checks;
    blt_bus_party pa (.own_val(a_drv), .dev_oe_n(a_oe_n), .dev_val(a_out), .lvl(a_in));
    blt_bus_party pb (.own_val(b_drv), .dev_oe_n(b_oe_n), .dev_val(b_out), .lvl(b_in));
    blt_transceiver uut (
        .sys_clk                (sys_clk),
        .rst                    (rst),
        .a_in                   (a_in),
        .a_out                  (a_out),
        .a_oe_n                 (a_oe_n),
        .b_in                   (b_in),
        .b_out                  (b_out),
        .b_oe_n                 (b_oe_n),
        .a_to_b_output_enable   (a_to_b_output_enable),
        .b_to_a_output_enable_n (b_to_a_output_enable_n),
        .a_to_b_latch_enable    (a_to_b_latch_enable),
        .b_to_a_latch_enable    (b_to_a_latch_enable),
        .a_to_b_capture_clock   (a_to_b_capture_clock),
        .b_to_a_capture_clock   (b_to_a_capture_clock)
    );
    initial
    begin
        sys_clk = 0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic step(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic set_ab(input logic le, ck, oe, input logic [35:0] d);
        {a_to_b_latch_enable, a_to_b_capture_clock, a_to_b_output_enable} = {le, ck, oe};
        a_drv = d;
    endtask
    task automatic set_ba(input logic le, ck, oe_n, input logic [35:0] d);
        {b_to_a_latch_enable, b_to_a_capture_clock, b_to_a_output_enable_n} = {le, ck, oe_n};
        b_drv = d;
    endtask
    task automatic chk(input logic [35:0] got, exp);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        mismatches = 0;
        total_checks = 0;
        rst = 1;
        set_ab(0, 0, 0, 36'h0);
        set_ba(0, 0, 1, 36'h0);
        step(8);
        rst = 0;
        step(8);
        set_ab(1, 0, 0, 36'h9_a5a5_a5a5);
        step(4);
        chk(b_out, 36'h9_a5a5_a5a5);
        chk({35'h0, b_oe_n}, 36'h1);
        set_ab(0, 0, 0, 36'h9_a5a5_a5a5);
        step(4);
        a_drv = 36'h1_2345_6789;
        step(5);
        chk(b_out, 36'h9_a5a5_a5a5);
        set_ab(0, 1, 1, 36'h1_2345_6789);
        step(5);
        chk(b_out, 36'h1_2345_6789);
        chk({35'h0, b_oe_n}, 36'h0);
        a_drv = 36'hf_0f0f_0f0f;
        step(5);
        a_to_b_capture_clock = 0;
        step(5);
        chk(b_out, 36'h1_2345_6789);
        $display("a-to-b modes done");
        set_ab(0, 0, 0, 36'hf_0f0f_0f0f);
        set_ba(1, 0, 0, 36'h5_5aa5_5aa5);
        step(9);
        chk(a_out, 36'h5_5aa5_5aa5);
        chk({35'h0, a_oe_n}, 36'h0);
        chk({35'h0, b_oe_n}, 36'h1);
        set_ba(0, 0, 0, 36'h0_dead_beef);
        step(5);
        chk(a_out, 36'h5_5aa5_5aa5);
        b_to_a_capture_clock = 1;
        step(5);
        chk(a_out, 36'h0_dead_beef);
        $display("b-to-a modes done");
        rst = 1;
        step(1);
        chk({35'h0, a_oe_n}, 36'h1);
        $display("reset done");
        finish_test();
    end
endmodule
`default_nettype wire
